// ===== adcseq_pkg.sv
// constants and types shared by the converter sample sequencer
package adcseq_pkg;
	localparam int SYS_CLK_HZ = 40000000;
	localparam int CONV_CLK_HZ = 10000000;
	localparam int CONV_HALF_SYS = SYS_CLK_HZ / (2 * CONV_CLK_HZ);
	localparam real TRIG_DELAY_CLK = 2.5;
	localparam int TRIG_DELAY_HALF = int'(TRIG_DELAY_CLK * 2.0);
	localparam int SH_BASE_CLK = 1;
	localparam int SEQ_PERIOD_BASE_CLK = 2;
	localparam int SIM_PERIOD_BASE_CLK = 3;
	localparam int RES_A_LAT_CLK = 4;
	localparam int RES_B_LAT_CLK = 5;
	localparam int FLAG_DELAY_SYS = 2;
	localparam int PIPE_STAGES = 4;
	localparam int RESULT_W = 12;
	localparam int NUM_CHANNELS = 16;
	localparam int CHAN_W = 4;
	localparam int ACQ_W = 4;
	localparam int ADDR_W = 8;
	localparam int DATA_W = 32;
	localparam logic [7:0] OFS_CTRL = 8'h00;
	localparam logic [7:0] OFS_CHAN = 8'h04;
	localparam logic [7:0] OFS_POWER = 8'h08;
	localparam logic [7:0] OFS_CMD = 8'h0C;
	localparam logic [7:0] OFS_STATUS = 8'h10;
	localparam logic [7:0] OFS_CLEAR = 8'h14;
	localparam logic [7:0] OFS_IRQ_EN = 8'h18;
	localparam logic [7:0] OFS_RES_A = 8'h1C;
	localparam logic [7:0] OFS_RES_B = 8'h20;
	localparam logic [7:0] OFS_STATE = 8'h24;
	localparam int CTRL_MODE_BIT = 0;
	localparam int CTRL_CONT_BIT = 1;
	localparam int CTRL_ACQ_LSB = 8;
	localparam int PWR_EN_BIT = 5;
	localparam int PWR_REF_LSB = 6;
	localparam int CMD_START_BIT = 0;
	localparam int ST_RES_A = 0;
	localparam int ST_RES_B = 1;
	localparam int ST_LOST = 2;
	localparam int ST_W = 3;
	localparam logic [CHAN_W-1:0] CHAN_RST = 4'h0;
	localparam logic [ACQ_W-1:0] ACQ_RST = 4'h0;
	localparam logic [2:0] PWR_RST = 3'h0;
	localparam logic [ST_W-1:0] IRQ_EN_RST = 3'h0;
	typedef enum logic [3:0] {
		ST_IDLE = 4'b0001,
		ST_DELAY = 4'b0010,
		ST_SAMPLE = 4'b0100,
		ST_GAP = 4'b1000
	} adcseq_state_t;
endpackage : adcseq_pkg

// ===== adcseq_clkdiv.sv
// half period tick divider for the converter clock
`timescale 1ns/1ps
module adcseq_clkdiv #(
	parameter int HALF = 2
) (
	input wire logic clk,
	input wire logic rst,
	input wire logic restart,
	output logic half_tick
);
	logic [7:0] cnt;
	wire cnt_last = (cnt == 8'(HALF - 1));
	assign half_tick = cnt_last;
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			cnt <= 8'h00;
		end else if (restart || cnt_last) begin
			cnt <= 8'h00;
		end else begin
			cnt <= cnt + 8'h01;
		end
	end
endmodule : adcseq_clkdiv

// ===== adcseq_top.sv
// converter sample sequencer with avalon register slave
// Overview of operation
// [R1] sixteen inputs in groups A and B, chosen by software channel select
// [R2] twelve bit results pass a four stage conversion pipeline
// [R3] mode bit 0 gives single channel sampling, 1 gives paired sampling
// [R4] pwm event, software start or external start pin begin a sequence
// [R5] sequential mode converts one channel per pulse, optionally continuous
// [R6] sequential channel captured on sample hold falling edge
// [R7] paired mode captures both channels together at the falling edge
// [R8] software picks only same index pairs A0/B0 through A7/B7
// [R9] sample hold lasts one plus acquisition setting clocks, bits 8 to 11
// [R10] sampling starts two and a half converter clocks after the trigger
// [R11] sequential result after 4 clocks, then every two plus setting
// [R12] paired: A after 4, B after 5, then every three plus setting
// [R13] interrupt flags set a few system cycles after result update
// [R14] software enables references then power before any conversion
// [R15] all latencies except the flag delay counted on the divided converter clock: delay, hold and gap in half periods, results in whole periods
//
// Local design decisions: the placing of the registers and register access over Avalon-MM.
`timescale 1ns/1ps
module adcseq_top import adcseq_pkg::*; #(
	parameter int CONV_HALF = CONV_HALF_SYS,
	parameter int STAGES = PIPE_STAGES
) (
	input wire logic clk,
	input wire logic rst,
	input wire logic [ADDR_W-1:0] avs_address,
	input wire logic avs_read,
	input wire logic avs_write,
	input wire logic [DATA_W-1:0] avs_writedata,
	output logic [DATA_W-1:0] avs_readdata,
	output logic avs_waitrequest,
	input wire logic pwm_trigger,
	input wire logic external_conversion_start,
	input wire logic [RESULT_W-1:0] analog_code_a,
	input wire logic [RESULT_W-1:0] analog_code_b,
	output logic converter_clock,
	output logic sample_hold,
	output logic [CHAN_W-1:0] mux_sel_a,
	output logic [CHAN_W-2:0] mux_sel_b,
	output logic [RESULT_W-1:0] result_a,
	output logic [RESULT_W-1:0] result_b,
	output logic result_a_update,
	output logic result_b_update,
	output logic irq
);
	localparam logic [5:0] DLY_LAST = 6'(TRIG_DELAY_HALF - 1);
	localparam logic [5:0] SH_LAST = 6'(2 * SH_BASE_CLK - 1);
	localparam logic [5:0] SEQ_GAP_LAST =
		6'(2 * (SEQ_PERIOD_BASE_CLK - SH_BASE_CLK) - 1);
	localparam logic [5:0] SIM_GAP_LAST =
		6'(2 * (SIM_PERIOD_BASE_CLK - SH_BASE_CLK) - 1);
	localparam int B_STAGES = STAGES + RES_B_LAT_CLK - RES_A_LAT_CLK;

	adcseq_state_t state;
	adcseq_state_t next_state;
	logic sampling_mode_select;
	logic continuous;
	logic [ACQ_W-1:0] acq_setting;
	logic [CHAN_W-1:0] chan_sel;
	logic [2:0] power_bits;
	logic [ST_W-1:0] status;
	logic [ST_W-1:0] irq_en;
	logic mode_l;
	logic [ACQ_W-1:0] acq_l;
	logic [5:0] ht_cnt;
	logic ext_meta;
	logic ext_sync;
	logic ext_prev;
	logic half_tick;
	logic [RESULT_W-1:0] pa [STAGES];
	logic [STAGES-1:0] pav;
	logic [RESULT_W-1:0] pb [B_STAGES];
	logic [B_STAGES-1:0] pbv;
	logic [FLAG_DELAY_SYS-1:0] dly_a;
	logic [FLAG_DELAY_SYS-1:0] dly_b;

	// bus decode
	wire bus_req = avs_read || avs_write;
	wire take = bus_req && avs_waitrequest;
	wire wr_en = avs_write && !avs_waitrequest;
	wire wr_ctrl = wr_en && (avs_address == OFS_CTRL);
	wire wr_chan = wr_en && (avs_address == OFS_CHAN);
	wire wr_pwr = wr_en && (avs_address == OFS_POWER);
	wire wr_cmd = wr_en && (avs_address == OFS_CMD);
	wire wr_clr = wr_en && (avs_address == OFS_CLEAR);
	wire wr_ien = wr_en && (avs_address == OFS_IRQ_EN);

	// trigger sources and power gating
	wire ext_rise = ext_sync && !ext_prev; // R4
	wire sw_start = wr_cmd && avs_writedata[CMD_START_BIT]; // R4
	wire trig_any = pwm_trigger || ext_rise || sw_start; // R4
	wire powered = power_bits[0] && (&power_bits[2:1]); // R14
	wire start_accept = (state == ST_IDLE) && trig_any && powered;
	wire trig_lost = (state != ST_IDLE) && trig_any && powered;

	// half period timing
	wire conv_tick = half_tick && !converter_clock; // R15
	wire [5:0] sh_last_cnt = {1'b0, acq_l, 1'b0} + SH_LAST; // R9
	wire [5:0] gap_last = mode_l ? SIM_GAP_LAST : SEQ_GAP_LAST; // R11 R12
	wire dly_done = half_tick && (ht_cnt == DLY_LAST); // R10
	wire sh_done = half_tick && (ht_cnt == sh_last_cnt); // R9
	wire gap_done = half_tick && (ht_cnt == gap_last);
	wire again = continuous && powered; // R5
	wire capture = (state == ST_SAMPLE) && sh_done; // R6 R7

	// status and interrupt
	wire [ST_W-1:0] set_vec = {trig_lost, dly_b[FLAG_DELAY_SYS-1],
		dly_a[FLAG_DELAY_SYS-1]}; // R13
	wire [ST_W-1:0] clr_vec = wr_clr ? avs_writedata[ST_W-1:0] : '0;
	wire [ST_W-1:0] next_status = (status & ~clr_vec) | set_vec;
	wire [ST_W-1:0] next_irq_en =
		wr_ien ? avs_writedata[ST_W-1:0] : irq_en;

	// channel routing, pairs forced to equal index
	wire [CHAN_W-1:0] next_sel_a =
		sampling_mode_select ? {1'b0, chan_sel[2:0]} : chan_sel; // R1 R8
	wire [CHAN_W-2:0] next_sel_b = chan_sel[2:0]; // R8

	// read mux
	wire [DATA_W-1:0] ctrl_rd = DATA_W'({acq_setting, 6'h00,
		continuous, sampling_mode_select});
	wire [DATA_W-1:0] rd_mux =
		(avs_address == OFS_CTRL) ? ctrl_rd :
		(avs_address == OFS_CHAN) ? DATA_W'(chan_sel) :
		(avs_address == OFS_POWER) ? DATA_W'({power_bits, 5'h00}) :
		(avs_address == OFS_STATUS) ? DATA_W'(status) :
		(avs_address == OFS_IRQ_EN) ? DATA_W'(irq_en) :
		(avs_address == OFS_RES_A) ? DATA_W'(result_a) :
		(avs_address == OFS_RES_B) ? DATA_W'(result_b) :
		(avs_address == OFS_STATE) ? DATA_W'(state) :
		32'h00000000;

	adcseq_clkdiv #(
		.HALF(CONV_HALF)
	) u_div (
		.clk(clk),
		.rst(rst),
		.restart(start_accept),
		.half_tick(half_tick)
	);

	always_comb begin
		next_state = state;
		unique case (state)
			ST_IDLE: begin
				if (start_accept) next_state = ST_DELAY;
			end
			ST_DELAY: begin
				if (dly_done) next_state = ST_SAMPLE; // R10
			end
			ST_SAMPLE: begin
				if (sh_done) next_state = ST_GAP; // R9
			end
			ST_GAP: begin
				if (gap_done) next_state = again ? ST_SAMPLE : ST_IDLE; // R5
			end
			default: next_state = ST_IDLE;
		endcase
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			state <= ST_IDLE;
			ht_cnt <= 6'h00;
		end else begin
			state <= next_state;
			if (start_accept || (half_tick && next_state != state)) begin
				ht_cnt <= 6'h00;
			end else if (half_tick) begin
				ht_cnt <= ht_cnt + 6'h01; // R15
			end
		end
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			converter_clock <= 1'b0;
		end else if (start_accept) begin
			converter_clock <= 1'b0;
		end else if (half_tick) begin
			converter_clock <= !converter_clock; // R15
		end
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			sample_hold <= 1'b0;
			mux_sel_a <= CHAN_RST;
			mux_sel_b <= 3'h0;
			mode_l <= 1'b0;
			acq_l <= ACQ_RST;
		end else begin
			sample_hold <= (next_state == ST_SAMPLE); // R9
			if (start_accept) begin
				mode_l <= sampling_mode_select; // R3
				acq_l <= acq_setting;
				mux_sel_a <= next_sel_a;
				mux_sel_b <= next_sel_b;
			end
		end
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			ext_meta <= 1'b0;
			ext_sync <= 1'b0;
			ext_prev <= 1'b0;
		end else begin
			ext_meta <= external_conversion_start;
			ext_sync <= ext_meta;
			ext_prev <= ext_sync;
		end
	end

	// conversion pipeline, A path and one stage longer B path
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			pa[0] <= '0;
			pav[0] <= 1'b0;
			pb[0] <= '0;
			pbv[0] <= 1'b0;
		end else if (conv_tick) begin
			pa[0] <= analog_code_a; // R2 R6
			pav[0] <= capture;
			pb[0] <= analog_code_b; // R7
			pbv[0] <= capture && mode_l; // R7
		end
	end

	genvar gi;
	generate
		for (gi = 1; gi < B_STAGES; gi++) begin : g_stage
			always_ff @(posedge clk or posedge rst) begin
				if (rst) begin
					pb[gi] <= '0;
					pbv[gi] <= 1'b0;
				end else if (conv_tick) begin
					pb[gi] <= pb[gi-1]; // R12
					pbv[gi] <= pbv[gi-1];
				end
			end
			if (gi < STAGES) begin : g_a
				always_ff @(posedge clk or posedge rst) begin
					if (rst) begin
						pa[gi] <= '0;
						pav[gi] <= 1'b0;
					end else if (conv_tick) begin
						pa[gi] <= pa[gi-1]; // R2
						pav[gi] <= pav[gi-1];
					end
				end
			end
		end
	endgenerate

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			result_a <= '0;
			result_b <= '0;
			result_a_update <= 1'b0;
			result_b_update <= 1'b0;
			dly_a <= '0;
			dly_b <= '0;
		end else begin
			result_a_update <= conv_tick && pav[STAGES-1]; // R11 R12
			result_b_update <= conv_tick && pbv[B_STAGES-1]; // R12
			if (conv_tick && pav[STAGES-1]) result_a <= pa[STAGES-1];
			if (conv_tick && pbv[B_STAGES-1]) result_b <= pb[B_STAGES-1];
			dly_a <= {dly_a[FLAG_DELAY_SYS-2:0], result_a_update}; // R13
			dly_b <= {dly_b[FLAG_DELAY_SYS-2:0], result_b_update}; // R13
		end
	end

	// register file and avalon slave
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			sampling_mode_select <= 1'b0;
			continuous <= 1'b0;
			acq_setting <= ACQ_RST;
			chan_sel <= CHAN_RST;
			power_bits <= PWR_RST;
			status <= '0;
			irq_en <= IRQ_EN_RST;
			irq <= 1'b0;
		end else begin
			if (wr_ctrl) begin
				sampling_mode_select <= avs_writedata[CTRL_MODE_BIT]; // R3
				continuous <= avs_writedata[CTRL_CONT_BIT];
				acq_setting <= avs_writedata[CTRL_ACQ_LSB+:ACQ_W]; // R9
			end
			if (wr_chan) chan_sel <= avs_writedata[CHAN_W-1:0]; // R1
			if (wr_pwr) power_bits <= avs_writedata[PWR_EN_BIT+:3];
			status <= next_status;
			irq_en <= next_irq_en;
			irq <= |(next_status & next_irq_en);
		end
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			avs_waitrequest <= 1'b1;
			avs_readdata <= '0;
		end else begin
			avs_waitrequest <= !take;
			if (take && avs_read) avs_readdata <= rd_mux;
		end
	end

	// checks
	localparam int DLY_SYS = TRIG_DELAY_HALF * CONV_HALF + 1;
	localparam int RES_A_SYS = 2 * RES_A_LAT_CLK * CONV_HALF;
	localparam int RES_B_SYS = 2 * RES_B_LAT_CLK * CONV_HALF;
	localparam int FLAG_PAST = FLAG_DELAY_SYS + 1;
	logic [11:0] sh_cnt;
	logic [11:0] rise_cnt;
	logic sh_prev;
	wire sh_rise = sample_hold && !sh_prev;
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			sh_cnt <= 12'h000;
			rise_cnt <= 12'h000;
			sh_prev <= 1'b0;
		end else begin
			sh_prev <= sample_hold;
			sh_cnt <= sample_hold ? sh_cnt + 12'h001 : 12'h000;
			rise_cnt <= sh_rise ? 12'h001 : rise_cnt + 12'h001;
		end
	end
	default clocking cb @(posedge clk); endclocking
	default disable iff (rst);
	a_trig_delay: assert property (start_accept |-> ##DLY_SYS sh_rise) // R10
		else $error("sampling did not start after trigger delay");
	a_sh_width: assert property ($fell(sample_hold) |-> // R9
		sh_cnt == 12'(2 * (acq_l + 1) * CONV_HALF))
		else $error("sample hold width wrong");
	a_result_a_lat: assert property ($fell(sample_hold) |-> // R11
		##RES_A_SYS result_a_update)
		else $error("A result latency wrong");
	a_result_b_lat: assert property ($fell(sample_hold) && mode_l |-> // R12
		##RES_B_SYS result_b_update)
		else $error("B result latency wrong");
	a_flag_after: assert property ($rose(status[ST_RES_A]) |-> // R13
		$past(result_a_update, FLAG_PAST))
		else $error("flag set without earlier result update");
	a_run_period: assert property (sh_rise && $past(state) == ST_GAP |-> // R11
		rise_cnt == 12'(2 * ((mode_l ? SIM_PERIOD_BASE_CLK :
		SEQ_PERIOD_BASE_CLK) + acq_l) * CONV_HALF))
		else $error("repeat period wrong");
	a_pair_index: assert property (sample_hold && mode_l |-> // R8
		mux_sel_a == {1'b0, mux_sel_b})
		else $error("pair index mismatch");
	a_power_gate: assert property (state == ST_IDLE && !powered |=> // R14
		state == ST_IDLE)
		else $error("conversion started without power");
	a_irq_level: assert property (irq == |(status & irq_en))
		else $error("interrupt level wrong");
	a_bus_answer: assert property (bus_req && avs_waitrequest |=>
		!avs_waitrequest)
		else $error("bus request not answered");
	a_bus_release: assert property (!avs_waitrequest |=> avs_waitrequest)
		else $error("waitrequest low too long");
	c_continuous: cover property (sh_rise && $past(state) == ST_GAP);
	c_pair_result: cover property (result_b_update);
	c_trig_lost: cover property (trig_lost);
	c_ext_start: cover property (ext_rise && start_accept);
endmodule : adcseq_top

// ===== adcseq_trig_model.sv
// pwm event source and external start pin model
`timescale 1ns/1ps
module adcseq_trig_model (
	input wire logic clk,
	input wire logic fire_pwm,
	input wire logic fire_ext,
	output logic pwm_trigger,
	output logic external_conversion_start
);
	initial begin
		pwm_trigger = 1'b0;
		external_conversion_start = 1'b0;
	end
	// one cycle pwm event, prompt
	always @(posedge clk) begin
		pwm_trigger <= fire_pwm;
	end
	// slow pin, held high for several cycles
	always @(posedge clk) begin
		if (fire_ext) begin
			external_conversion_start <= 1'b1;
			repeat (6) @(posedge clk);
			external_conversion_start <= 1'b0;
		end
	end
endmodule : adcseq_trig_model

// ===== adcseq_top_tb_top.sv
// self checking testbench of the converter sample sequencer
`timescale 1ns/1ps
module adcseq_top_tb_top import adcseq_pkg::*;;
	localparam int HT = 2;
	logic clk, rst, avs_read, avs_write, avs_waitrequest;
	logic [ADDR_W-1:0] avs_address;
	logic [DATA_W-1:0] avs_writedata, avs_readdata;
	logic pwm_trigger, external_conversion_start, fire_pwm, fire_ext;
	logic [RESULT_W-1:0] analog_code_a, analog_code_b, result_a, result_b;
	logic converter_clock, sample_hold, irq;
	logic result_a_update, result_b_update;
	logic [CHAN_W-1:0] mux_sel_a;
	logic [CHAN_W-2:0] mux_sel_b;
	int err_count, n_checks, cyc;

	adcseq_top #(.CONV_HALF(HT)) i_adcseq_top (.clk(clk), .rst(rst),
		.avs_address(avs_address), .avs_read(avs_read),
		.avs_write(avs_write), .avs_writedata(avs_writedata),
		.avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
		.pwm_trigger(pwm_trigger),
		.external_conversion_start(external_conversion_start),
		.analog_code_a(analog_code_a), .analog_code_b(analog_code_b),
		.converter_clock(converter_clock), .sample_hold(sample_hold),
		.mux_sel_a(mux_sel_a), .mux_sel_b(mux_sel_b),
		.result_a(result_a), .result_b(result_b),
		.result_a_update(result_a_update),
		.result_b_update(result_b_update), .irq(irq));
	adcseq_trig_model i_adcseq_trig_model (.clk(clk), .fire_pwm(fire_pwm),
		.fire_ext(fire_ext), .pwm_trigger(pwm_trigger),
		.external_conversion_start(external_conversion_start));

	initial begin
		clk = 1'b0;
		forever #12.5 clk = ~clk;
	end

	task end_sim;
		$display("checks %0d errors %0d", n_checks, err_count);
		if (err_count == 0 && n_checks > 0) begin
			$display("*** PASS ***");
		end else begin
			$display("*** FAIL ***");
		end
		$finish;
	endtask : end_sim

	always @(posedge clk) begin
		cyc <= cyc + 1;
		if (cyc == 20000) begin
			err_count++;
			end_sim();
		end
	end

	task chk(input string nm, input logic [31:0] seen, input logic [31:0] ex);
		n_checks++;
		if (seen !== ex) begin
			err_count++;
			$display("CHECK FAILED %s expected %0h seen %0h", nm, ex, seen);
		end
	endtask : chk

	// avalon access: hold until waitrequest sampled low
	task bus(input logic wr, input logic [7:0] a, input logic [31:0] d,
		output logic [31:0] q);
		@(posedge clk);
		avs_address <= a;
		avs_writedata <= d;
		avs_write <= wr;
		avs_read <= ~wr;
		do begin
			@(posedge clk);
		end while (avs_waitrequest !== 1'b0);
		q = avs_readdata;
		avs_write <= 1'b0;
		avs_read <= 1'b0;
	endtask : bus

	task wr(input logic [7:0] a, input logic [31:0] d);
		logic [31:0] q;
		bus(1'b1, a, d, q);
	endtask : wr

	task rd_chk(input string nm, input logic [7:0] a, input logic [31:0] ex);
		logic [31:0] q;
		bus(1'b0, a, 32'h0, q);
		chk(nm, q, ex);
	endtask : rd_chk

	// edges until the chosen output shows the level
	task cnt_to(input int sel, input logic lvl, output int n);
		logic v;
		n = 0;
		do begin
			@(posedge clk);
			n++;
			case (sel)
				0: v = sample_hold;
				1: v = result_a_update;
				2: v = result_b_update;
				default: v = irq;
			endcase
		end while (v !== lvl && n < 2000);
	endtask : cnt_to

	task pulse_pwm;
		fire_pwm <= 1'b1;
		@(posedge clk);
		fire_pwm <= 1'b0;
	endtask : pulse_pwm

	// one window after its rise: width, latencies, flags
	task run_conv(input logic md, input int acq, input logic [31:0] st);
		int n;
		cnt_to(0, 1'b0, n);
		chk("sh width", n, 2 * (SH_BASE_CLK + acq) * HT);
		cnt_to(1, 1'b1, n);
		chk("a latency", n, 2 * RES_A_LAT_CLK * HT);
		chk("result a", result_a, analog_code_a);
		cnt_to(3, 1'b1, n);
		chk("flag delay", n, FLAG_DELAY_SYS + 1);
		if (md) begin
			cnt_to(2, 1'b1, n);
			chk("b latency", n, 2 * HT - FLAG_DELAY_SYS - 1);
			chk("result b", result_b, analog_code_b);
			repeat (FLAG_DELAY_SYS + 1) @(posedge clk);
		end
		rd_chk("status", OFS_STATUS, st);
		wr(OFS_CLEAR, 32'h7);
		rd_chk("status clr", OFS_STATUS, 32'h0);
		chk("irq clr", irq, 1'b0);
		rd_chk("res a reg", OFS_RES_A, 32'(analog_code_a));
	endtask : run_conv

	task t_regs;
		int i;
		logic s;
		rd_chk("ctrl rst", OFS_CTRL, 32'h0);
		rd_chk("power rst", OFS_POWER, 32'h0);
		rd_chk("irq en rst", OFS_IRQ_EN, 32'h0);
		wr(8'h3C, 32'hFFFF);
		rd_chk("unmapped", 8'h3C, 32'h0);
		rd_chk("clear wo", OFS_CLEAR, 32'h0);
		pulse_pwm();
		s = 1'b0;
		for (i = 0; i < 40; i++) begin
			@(posedge clk);
			s = s | sample_hold;
		end
		chk("unpowered", s, 1'b0);
		wr(OFS_POWER, 32'hC0);
		wr(OFS_POWER, 32'hE0);
		wr(OFS_IRQ_EN, 32'h7);
	endtask : t_regs

	task t_seq_pwm;
		int n;
		wr(OFS_CTRL, 32'h0);
		wr(OFS_CHAN, 32'hB);
		analog_code_a <= 12'hA5C;
		pulse_pwm();
		cnt_to(0, 1'b1, n);
		chk("trig delay", n, TRIG_DELAY_HALF * HT + 2);
		chk("seq chan", mux_sel_a, 4'hB);
		chk("conv clk", converter_clock, 1'b1);
		run_conv(1'b0, 0, 32'h1);
	endtask : t_seq_pwm

	task t_pair_sw;
		int n;
		wr(OFS_CTRL, 32'h0F01);
		wr(OFS_CHAN, 32'hD);
		analog_code_a <= 12'h3C1;
		analog_code_b <= 12'hE07;
		wr(OFS_CMD, 32'h1);
		cnt_to(0, 1'b1, n);
		chk("pair a", mux_sel_a, 4'h5);
		chk("pair b", mux_sel_b, 3'h5);
		run_conv(1'b1, 15, 32'h3);
	endtask : t_pair_sw

	task t_ext_cont;
		int n, i;
		logic s, p;
		wr(OFS_IRQ_EN, 32'h0);
		wr(OFS_CTRL, 32'h0102);
		wr(OFS_CHAN, 32'h3);
		fire_ext <= 1'b1;
		@(posedge clk);
		fire_ext <= 1'b0;
		cnt_to(0, 1'b1, n);
		chk("ext start", n < 100, 1'b1);
		cnt_to(0, 1'b0, n);
		chk("cont width", n, 4 * HT);
		cnt_to(0, 1'b1, n);
		chk("cont gap", n, 2 * (SEQ_PERIOD_BASE_CLK + 1) * HT - 4 * HT);
		pulse_pwm();
		wr(OFS_CTRL, 32'h0100);
		s = 1'b0;
		p = 1'b1;
		for (i = 0; i < 60; i++) begin
			@(posedge clk);
			s = s | (sample_hold & ~p);
			p = sample_hold;
			if (i > 12) s = s | sample_hold;
		end
		chk("cont stop", s, 1'b0);
		rd_chk("lost flag", OFS_STATUS, 32'h5);
		chk("irq masked", irq, 1'b0);
		wr(OFS_CLEAR, 32'h7);
	endtask : t_ext_cont

	initial begin
		rst = 1'b1;
		avs_address = '0;
		avs_read = 1'b0;
		avs_write = 1'b0;
		avs_writedata = '0;
		fire_pwm = 1'b0;
		fire_ext = 1'b0;
		analog_code_a = 12'h000;
		analog_code_b = 12'h000;
		err_count = 0;
		n_checks = 0;
		cyc = 0;
		repeat (5) @(posedge clk);
		rst <= 1'b0;
		t_regs();
		t_seq_pwm();
		t_pair_sw();
		t_ext_cont();
		end_sim();
	end
endmodule : adcseq_top_tb_top
